// [rtl/smtc_map.vh]
// Purpose: constants for the static memory timing configuration block
// Assumes: included by smtc_core.v only
// Notes:   word offsets, field positions, masks, reset values
`ifndef SMTC_MAP_VH
`define SMTC_MAP_VH
// chip selects and register grouping
`define SMTC_NCS        8
`define SMTC_NWORD      32
`define SMTC_CS_STRIDE  8'h10
`define SMTC_OFF_SETUP  2'h0
`define SMTC_OFF_PULSE  2'h1
`define SMTC_OFF_CYCLE  2'h2
`define SMTC_OFF_MODE   2'h3
`define SMTC_RST_WORD   32'h00000000
// readable bits of each word, others read zero
`define SMTC_MASK_SETUP 32'h3F3F3F3F
`define SMTC_MASK_PULSE 32'h7F7F7F7F
`define SMTC_MASK_CYCLE 32'h01FF01FF
`define SMTC_MASK_MODE  32'h311F3133
// setup word fields (6 bits each)
`define SMTC_SU_WS      5:0
`define SMTC_SU_SW      13:8
`define SMTC_SU_RS      21:16
`define SMTC_SU_SR      29:24
// pulse word fields (7 bits each)
`define SMTC_PU_WS      6:0
`define SMTC_PU_SW      14:8
`define SMTC_PU_RS      22:16
`define SMTC_PU_SR      30:24
// cycle word fields (9 bits each)
`define SMTC_CY_WR      8:0
`define SMTC_CY_RD      24:16
// mode word fields
`define SMTC_MD_RDCTL   0
`define SMTC_MD_WRCTL   1
`define SMTC_MD_WAIT    5:4
`define SMTC_MD_BAT     8
`define SMTC_MD_DBW     13:12
`define SMTC_MD_FLOAT   19:16
`define SMTC_MD_FOPT    20
`define SMTC_MD_PAGE_ENABLE    24
`define SMTC_MD_PS      29:28
// wait handling and bus width codes
`define SMTC_WAIT_FROZEN 2'h2
`define SMTC_WAIT_READY  2'h3
`define SMTC_DBW_8       2'h0
`define SMTC_DBW_16      2'h1
`define SMTC_DBW_32      2'h2
`define SMTC_LANES_16    4'h3
`endif

// [rtl/smtc_core.v]
// Purpose: per-chip-select timing registers and static memory strobe engine
// Assumes: classic wishbone slave, one clock, synchronous active-high reset
// Notes:   strobes are active low; timing applies after a mode word write
// How it works
// - four words per chip select, 0x10 stride
// - setup equals 128*bit5 plus bits 4:0
// - pulse equals 256*bit6 plus bits 5:0
// - total equals bits 8:7 *256 plus 6:0
// - hold fills remaining cycles of total
// - page reads inside page use strobe pulse
// - first page access uses select read pulse
// - read control bit picks read controlling strobe
// - write control bit picks write controlling strobe
// - wait sampled only in controlling pulse phase
// - wait field: off, reserved, frozen, ready
// - frozen wait halts counting, resumes in place
// - ready wait extends pulse end until high
// - byte-write scheme uses lane write strobes
// - byte-select scheme uses lane selects
// - width field selects 8, 16, 32 bits
// - float count gives release cycles 0..15
// - float plus one cycle blocks other selects
// - optimized float overlaps next access setup
// - page enable gives page mode reads
// - page size field selects 4 to 32 bytes
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "smtc_map.vh"
module smtc_core (
   // clock, reset, enable
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   // wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // access request
   input  wire        acc_req_i,
   input  wire        acc_we_i,
   input  wire [2:0]  acc_cs_i,
   input  wire [25:0] acc_addr_i,
   input  wire [3:0]  acc_be_i,
   output reg         acc_done_o,
   output reg         acc_busy_o,
   output reg         page_hit_o,
   // memory side
   input  wire        external_wait_n_i,
   output reg  [7:0]  memory_select_n_o,
   output reg         read_strobe_n_o,
   output reg         write_strobe_n_o,
   output reg  [3:0]  lane_write_strobe_n_o,
   output reg  [3:0]  byte_lane_select_n_o,
   output reg         bus_float_o
);
   // one-hot engine states
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_LOAD = 3'b010;
   localparam [2:0] ST_ACC  = 3'b100;

   // setup decode, 8 bits wide
   function [9:0] dec_su;
      input [5:0] f;
      begin
         dec_su = {2'h0, f[5], 2'h0, f[4:0]};
      end
   endfunction

   // pulse decode, 9 bits wide
   function [9:0] dec_pu;
      input [6:0] f;
      begin
         dec_pu = {1'b0, f[6], 2'h0, f[5:0]};
      end
   endfunction

   // total cycle decode
   function [9:0] dec_cy;
      input [8:0] f;
      begin
         dec_cy = {f[8:7], 1'b0, f[6:0]};
      end
   endfunction

   // readable-bit mask per word kind
   function [31:0] word_mask;
      input [1:0] k;
      begin
         case (k)
            `SMTC_OFF_SETUP: word_mask = `SMTC_MASK_SETUP;
            `SMTC_OFF_PULSE: word_mask = `SMTC_MASK_PULSE;
            `SMTC_OFF_CYCLE: word_mask = `SMTC_MASK_CYCLE;
            default:         word_mask = `SMTC_MASK_MODE;
         endcase
      end
   endfunction

   // staged and applied configuration words
   reg  [31:0] stage_q [0:`SMTC_NWORD-1];
   reg  [31:0] live_q  [0:`SMTC_NWORD-1];
   reg         apply_q;                      // copy staged to live
   integer     i;                            // register file loop index
   integer     j;                            // byte merge loop index
   integer     k;                            // select output loop index

   // wishbone decode
   wire        wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire        wb_hit   = (wb_adr_i[7:0] < (`SMTC_CS_STRIDE * 8'h08));
   wire [4:0]  wb_idx   = wb_adr_i[6:2];     // cs*4 + word
   wire [31:0] wb_old   = stage_q[wb_idx];
   reg  [31:0] wb_new;                       // merged write data

   // byte-lane merge of write data
   always @* begin
      wb_new = wb_old;
      for (j = 0; j < 4; j = j + 1) begin
         if (wb_sel_i[j]) begin
            wb_new[j*8 +: 8] = wb_dat_i[j*8 +: 8];
         end
      end
      wb_new = wb_new & word_mask(wb_idx[1:0]);
   end

   // register file, bus answer and apply
   always @(posedge clk_i) begin
      if (rst_i) begin
         for (i = 0; i < `SMTC_NWORD; i = i + 1) begin
            stage_q[i] <= `SMTC_RST_WORD;
            live_q[i]  <= `SMTC_RST_WORD;
         end
         apply_q  <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else if (ce_i) begin
         wb_ack_o <= wb_req;                 // one wait state, one-cycle ack
         apply_q  <= 1'b0;
         if (wb_req) begin
            // unmapped reads return zero, writes dropped
            wb_dat_o <= wb_hit ? wb_old : 32'h00000000;
            if (wb_we_i && wb_hit) begin
               stage_q[wb_idx] <= wb_new;
               // any mode word write commits all groups
               if (wb_idx[1:0] == `SMTC_OFF_MODE) begin
                  apply_q <= 1'b1;
               end
            end
         end
         if (apply_q) begin
            for (i = 0; i < `SMTC_NWORD; i = i + 1) begin
               live_q[i] <= stage_q[i];
            end
         end
      end
   end

   // engine state
   reg  [2:0]  st_q;
   reg  [9:0]  cnt_q;                        // position in access
   reg  [2:0]  cs_q;
   reg         we_q;
   reg  [3:0]  be_q;
   reg  [25:0] addr_q;
   reg  [31:0] su_q, pu_q, cy_q, md_q;       // latched timing
   reg         hit_q;                        // page hit of this access
   reg  [4:0]  float_q;                      // bus reserved cycles left
   reg         fopt_q;                       // optimize of floating cs
   reg  [2:0]  fcs_q;                        // cs that floats the bus
   reg         pg_open_q;
   reg  [2:0]  pg_cs_q;
   reg  [25:0] pg_addr_q;

   // request side lookup of live config
   wire [31:0] n_su = live_q[{acc_cs_i, `SMTC_OFF_SETUP}];
   wire [31:0] n_md = live_q[{acc_cs_i, `SMTC_OFF_MODE}];
   reg  [9:0]  n_ctl_su;                     // next access controlling setup
   reg  [25:0] pg_mask;                      // page-number bits
   wire        n_page = n_md[`SMTC_MD_PAGE_ENABLE] & ~acc_we_i;
   wire        n_hit  = n_page & pg_open_q & (pg_cs_q == acc_cs_i) &
                        (((acc_addr_i ^ pg_addr_q) & pg_mask) == 26'h0);

   // next access setup and page mask
   always @* begin
      if (acc_we_i) begin
         n_ctl_su = n_md[`SMTC_MD_WRCTL] ? dec_su(n_su[`SMTC_SU_WS])
                                         : dec_su(n_su[`SMTC_SU_SW]);
      end else begin
         n_ctl_su = n_md[`SMTC_MD_RDCTL] ? dec_su(n_su[`SMTC_SU_RS])
                                         : dec_su(n_su[`SMTC_SU_SR]);
      end
      if (n_page) begin
         n_ctl_su = 10'h000;                 // page reads have no setup
      end
      case (n_md[`SMTC_MD_PS])
         2'h0:    pg_mask = 26'h3FFFFFC;     // 4-byte page
         2'h1:    pg_mask = 26'h3FFFFF8;     // 8-byte page
         2'h2:    pg_mask = 26'h3FFFFF0;     // 16-byte page
         default: pg_mask = 26'h3FFFFE0;     // 32-byte page
      endcase
   end

   // bus free for a new access, float honoured
   wire        float_ok = (float_q == 5'h00) |
                          (fopt_q & (n_ctl_su >= {5'h00, float_q})) |
                          (acc_cs_i == fcs_q & fopt_q);
   wire        take     = st_q[0] & acc_req_i & ~acc_done_o & float_ok;

   // decoded timing of the latched access
   wire        rd       = ~we_q;
   wire        page     = md_q[`SMTC_MD_PAGE_ENABLE] & rd;
   reg  [9:0]  sel_su, sel_pu, dat_su, dat_pu, tot;
   reg  [9:0]  ctl_su, ctl_pu;
   reg         ctl_dat;                      // data strobe controls

   // per-direction timing selection
   always @* begin
      if (rd) begin
         sel_su  = dec_su(su_q[`SMTC_SU_SR]);
         sel_pu  = dec_pu(pu_q[`SMTC_PU_SR]);
         dat_su  = dec_su(su_q[`SMTC_SU_RS]);
         dat_pu  = dec_pu(pu_q[`SMTC_PU_RS]);
         tot     = dec_cy(cy_q[`SMTC_CY_RD]);
         ctl_dat = md_q[`SMTC_MD_RDCTL];
      end else begin
         sel_su  = dec_su(su_q[`SMTC_SU_SW]);
         sel_pu  = dec_pu(pu_q[`SMTC_PU_SW]);
         dat_su  = dec_su(su_q[`SMTC_SU_WS]);
         dat_pu  = dec_pu(pu_q[`SMTC_PU_WS]);
         tot     = dec_cy(cy_q[`SMTC_CY_WR]);
         ctl_dat = md_q[`SMTC_MD_WRCTL];
      end
      if (page) begin
         // strobes low whole access, one length for both
         sel_su = 10'h000;
         dat_su = 10'h000;
         sel_pu = hit_q ? dec_pu(pu_q[`SMTC_PU_RS])
                        : dec_pu(pu_q[`SMTC_PU_SR]);
         dat_pu = sel_pu;
         tot    = sel_pu;
      end
      if (tot == 10'h000) begin
         tot = 10'h001;                      // never a zero-length access
      end
      ctl_su = ctl_dat ? dat_su : sel_su;
      ctl_pu = ctl_dat ? dat_pu : sel_pu;
   end

   // wait handling in the controlling pulse only
   wire [9:0]  ctl_end  = ctl_su + ctl_pu;
   wire        in_ctl   = (cnt_q >= ctl_su) & (cnt_q < ctl_end);
   wire        last_ctl = (cnt_q == ctl_end - 10'h001);
   wire [1:0]  wmode    = page ? 2'h0 : md_q[`SMTC_MD_WAIT];
   wire        freeze   = st_q[2] & ~external_wait_n_i &
                          (((wmode == `SMTC_WAIT_FROZEN) & in_ctl) |
                           ((wmode == `SMTC_WAIT_READY) & last_ctl));
   wire        fin      = st_q[2] & ~freeze & (cnt_q >= tot - 10'h001);

   // next state and count
   reg  [2:0]  st_d;
   reg  [9:0]  cnt_d;
   always @* begin
      st_d  = st_q;
      cnt_d = cnt_q;
      case (st_q)
         ST_IDLE: begin
            if (take) begin
               st_d = ST_LOAD;
            end
         end
         ST_LOAD: begin
            st_d  = ST_ACC;                  // config now latched
            cnt_d = 10'h000;
         end
         ST_ACC: begin
            if (fin) begin
               st_d = ST_IDLE;
            end else if (!freeze) begin
               cnt_d = cnt_q + 10'h001;      // hold fills to total
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   // lane selection from width and byte enables
   wire [1:0]  bus_width_sel   = md_q[`SMTC_MD_DBW];
   wire        wide  = (bus_width_sel == `SMTC_DBW_16) | (bus_width_sel == `SMTC_DBW_32);
   wire [3:0]  lanes = (bus_width_sel == `SMTC_DBW_16) ? (be_q & `SMTC_LANES_16) : be_q;
   wire        bwr   = wide & md_q[`SMTC_MD_BAT];
   // strobe phases for the next count
   wire        act_d = (st_d == ST_ACC);
   wire        sel_d = act_d & (cnt_d >= sel_su) & (cnt_d < sel_su + sel_pu);
   wire        dat_d = act_d & (cnt_d >= dat_su) & (cnt_d < dat_su + dat_pu);

   // engine registers and memory-side strobes
   always @(posedge clk_i) begin
      if (rst_i) begin
         st_q                  <= ST_IDLE;
         cnt_q                 <= 10'h000;
         cs_q                  <= 3'h0;
         we_q                  <= 1'b0;
         be_q                  <= 4'h0;
         addr_q                <= 26'h0000000;
         su_q                  <= `SMTC_RST_WORD;
         pu_q                  <= `SMTC_RST_WORD;
         cy_q                  <= `SMTC_RST_WORD;
         md_q                  <= `SMTC_RST_WORD;
         hit_q                 <= 1'b0;
         float_q               <= 5'h00;
         fopt_q                <= 1'b0;
         fcs_q                 <= 3'h0;
         pg_open_q             <= 1'b0;
         pg_cs_q               <= 3'h0;
         pg_addr_q             <= 26'h0000000;
         acc_done_o            <= 1'b0;
         acc_busy_o            <= 1'b0;
         page_hit_o            <= 1'b0;
         memory_select_n_o     <= 8'hFF;
         read_strobe_n_o       <= 1'b1;
         write_strobe_n_o      <= 1'b1;
         lane_write_strobe_n_o <= 4'hF;
         byte_lane_select_n_o  <= 4'hF;
         bus_float_o           <= 1'b0;
      end else if (ce_i) begin
         st_q       <= st_d;
         cnt_q      <= cnt_d;
         acc_done_o <= fin;
         acc_busy_o <= (st_d != ST_IDLE);
         // latch request and its applied timing
         if (take) begin
            cs_q   <= acc_cs_i;
            we_q   <= acc_we_i;
            be_q   <= acc_be_i;
            addr_q <= acc_addr_i;
            su_q   <= n_su;
            pu_q   <= live_q[{acc_cs_i, `SMTC_OFF_PULSE}];
            cy_q   <= live_q[{acc_cs_i, `SMTC_OFF_CYCLE}];
            md_q   <= n_md;
            hit_q  <= n_hit;
            // any other access closes the page
            pg_open_q  <= n_page;
            pg_cs_q    <= acc_cs_i;
            pg_addr_q  <= acc_addr_i;
            page_hit_o <= n_hit;
         end
         // float starts as the read controlling strobe rises
         if (st_q[2] & rd & ~freeze & last_ctl) begin
            float_q <= {1'b0, md_q[`SMTC_MD_FLOAT]} + 5'h01;
            fopt_q  <= md_q[`SMTC_MD_FOPT];
            fcs_q   <= cs_q;
         end else if (float_q != 5'h00) begin
            float_q <= float_q - 5'h01;
         end
         bus_float_o <= (float_q > 5'h01);
         // select and strobes from next phase
         for (k = 0; k < `SMTC_NCS; k = k + 1) begin
            memory_select_n_o[k] <= ~(sel_d & (cs_q == k[2:0]));
         end
         read_strobe_n_o  <= ~(dat_d & rd);
         write_strobe_n_o <= ~(dat_d & we_q & ~bwr);
         lane_write_strobe_n_o <= ~({4{dat_d & we_q & bwr}} & lanes);
         byte_lane_select_n_o  <= ~({4{sel_d & wide & ~bwr}} & lanes);
      end
   end

endmodule // smtc_core

// [tb/smtc_core_monitor.sv]
// Purpose: port-level checks on the timing configuration block
// Assumes: one clock, synchronous active-high reset
// Notes:   attached to smtc_core by the bind at the foot
`timescale 1ns/1ps
module smtc_core_monitor (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // register bus
   input  wire logic       ce_i,
   input  wire logic       wb_cyc_i,
   input  wire logic       wb_stb_i,
   input  wire logic       wb_ack_o,
   // access engine
   input  wire logic       acc_done_o,
   input  wire logic       acc_busy_o,
   // memory side
   input  wire logic [7:0] memory_select_n_o,
   input  wire logic       read_strobe_n_o,
   input  wire logic       write_strobe_n_o,
   input  wire logic [3:0] lane_write_strobe_n_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // bus request not yet answered
   sequence s_wb_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   endsequence
   // engine neither busy nor finishing
   sequence s_idle;
      !acc_busy_o && !acc_done_o;
   endsequence
   a_ack_follows_req: assert property (s_wb_req |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("ack without request");
   a_done_one_cycle: assert property (acc_done_o |=> !acc_done_o)
      else $error("done longer than one cycle");
   a_done_ends_busy: assert property (acc_done_o |-> !acc_busy_o)
      else $error("busy still set with done");
   a_one_select: assert property ($onehot0(~memory_select_n_o))
      else $error("two chip selects low together");
   a_idle_strobes_high: assert property (s_idle |-> &memory_select_n_o &&
      read_strobe_n_o && write_strobe_n_o && &lane_write_strobe_n_o)
      else $error("strobe low while engine idle");
   a_read_no_lanes: assert property (!read_strobe_n_o |->
      &lane_write_strobe_n_o && write_strobe_n_o)
      else $error("write strobe during read");
endmodule // smtc_core_monitor
bind smtc_core smtc_core_monitor mon_u (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .acc_done_o(acc_done_o),
   .acc_busy_o(acc_busy_o), .memory_select_n_o(memory_select_n_o),
   .read_strobe_n_o(read_strobe_n_o), .write_strobe_n_o(write_strobe_n_o),
   .lane_write_strobe_n_o(lane_write_strobe_n_o));

// [tb/smtc_mem_model.sv]
// Purpose: external static device answering on the wait line
// Assumes: wait line has a pull-up, so a released line reads high
// Notes:   holds wait low a set count of cycles into each strobe pulse
`timescale 1ns/1ps
module smtc_mem_model (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // strobe watched and wait length
   input  wire logic       strobe_n_i,
   input  wire logic [3:0] wait_len_i,
   // wait line back to the controller
   output logic            external_wait_n_o
);
   logic [3:0] cnt_q; // wait cycles already given
   // wait low from the cycle after the strobe falls
   always @(posedge clk_i) begin
      if (rst_i || strobe_n_i) begin
         cnt_q <= 4'h0;
         external_wait_n_o <= 1'h1; // released, pull-up wins
      end else if (cnt_q < wait_len_i) begin
         cnt_q <= cnt_q + 4'h1;
         external_wait_n_o <= 1'h0; // not ready yet
      end else begin
         external_wait_n_o <= 1'h1; // ready
      end
   end
endmodule // smtc_mem_model

// [tb/tb_top.sv]
// Purpose: self-checking bench for the timing configuration block
// Assumes: 100 MHz clock, reset held six cycles, ce dropped once
// Notes:   expected figures come from the field decodes
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
   logic        clk_i = 1'h0;  // bench clock
   logic        ce_i = 1'h1;   // clock enable
   logic        rst_i = 1'h1;  // synchronous reset
   logic        wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic        wb_ack_o, acc_done_o, acc_busy_o, page_hit_o, wait_n;
   logic        acc_req_i = 1'h0, acc_we_i = 1'h0, read_strobe_n_o, write_strobe_n_o;
   logic [2:0]  acc_cs_i = 3'h0;
   logic [25:0] acc_addr_i = 26'h0;
   logic [3:0]  acc_be_i = 4'hF, wait_len = 4'h0, lw, bs, lane_write_strobe_n_o;
   logic [3:0]  byte_lane_select_n_o;
   logic [7:0]  memory_select_n_o;
   logic        bus_float_o, wl;
   int          err_count = 0, checked = 0, n, rl, i;
   // expected read masks and lane tables
   logic [31:0] mask [4] = '{32'h3F3F3F3F, 32'h7F7F7F7F, 32'h01FF01FF, 32'h311F3133};
   logic [31:0] wmd [3] = '{32'h00002003, 32'h00002103, 32'h00000103};
   logic [3:0]  elw [3] = '{4'hF, 4'hA, 4'hF};
   logic [3:0]  ebs [3] = '{4'hA, 4'hF, 4'hF};
   logic [25:0] pa [3] = '{26'h10, 26'h11, 26'h14};
   int          pn [3] = '{8, 5, 8};
   int          wn [4] = '{9, 9, 11, 10};
   int          wr [4] = '{3, 3, 5, 4};
   always #5 clk_i = ~clk_i;
   smtc_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .acc_req_i(acc_req_i), .acc_we_i(acc_we_i), .acc_cs_i(acc_cs_i),
      .acc_addr_i(acc_addr_i), .acc_be_i(acc_be_i), .acc_done_o(acc_done_o),
      .acc_busy_o(acc_busy_o), .page_hit_o(page_hit_o), .external_wait_n_i(wait_n),
      .memory_select_n_o(memory_select_n_o), .read_strobe_n_o(read_strobe_n_o),
      .write_strobe_n_o(write_strobe_n_o), .lane_write_strobe_n_o(lane_write_strobe_n_o),
      .byte_lane_select_n_o(byte_lane_select_n_o), .bus_float_o(bus_float_o));
   smtc_mem_model mem_u (.clk_i(clk_i), .rst_i(rst_i), .strobe_n_i(read_strobe_n_o),
      .wait_len_i(wait_len), .external_wait_n_o(wait_n));
   // one classic wishbone cycle, read data in q
   task automatic wbx(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      // wait for ack however long; only the watchdog ends a hang
      do @(posedge clk_i); while (wb_ack_o !== 1'h1);
      q = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
   endtask
   // four words of one chip select, mode word last if asked
   task automatic cfg(input logic [2:0] cs, input logic [31:0] su, pu, cy, md,
                      input logic mw);
      wbx(1'h1, {1'h0, cs, 4'h0}, su);
      wbx(1'h1, {1'h0, cs, 4'h4}, pu);
      wbx(1'h1, {1'h0, cs, 4'h8}, cy);
      if (mw) wbx(1'h1, {1'h0, cs, 4'hC}, md);
   endtask
   // one access; cycles, read strobe low count and lane patterns
   task automatic acc(input logic we, input logic [2:0] cs, input logic [25:0] a,
                      input logic [3:0] be);
      @(posedge clk_i);
      acc_req_i <= 1'h1;
      acc_we_i <= we;
      acc_cs_i <= cs;
      acc_addr_i <= a;
      acc_be_i <= be;
      rl = 0;
      lw = 4'hF;
      bs = 4'hF;
      wl = 1'h0;
      for (n = 1; n < 2000; n++) begin
         @(posedge clk_i);
         rl += (read_strobe_n_o === 1'h0);
         lw &= lane_write_strobe_n_o;
         bs &= byte_lane_select_n_o;
         wl |= ~write_strobe_n_o;
         if (acc_done_o === 1'h1) break;
      end
      acc_req_i <= 1'h0;
   endtask
   // verdict and end of run
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      #200000;
      err_count++;
      conclude();
   end
   // main sequence
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'h0;
      // staged timing unused until a mode word is written
      cfg(3'h1, 32'h01010101, 32'h03030303, 32'h00060006, 32'h0, 1'h0);
      acc(1'h0, 3'h1, 26'h0, 4'hF);
      `CHK("stale cycles", 4, n)
      wbx(1'h1, 8'h1C, 32'h00002003);
      acc(1'h0, 3'h1, 26'h0, 4'hF);
      `CHK("applied cycles", 9, n)
      // enable low for three edges freezes the access in place
      fork
         acc(1'h0, 3'h1, 26'h0, 4'hF);
         begin
            repeat (4) @(posedge clk_i);
            ce_i <= 1'h0;
            repeat (3) @(posedge clk_i);
            ce_i <= 1'h1;
         end
      join
      `CHK("frozen cycles", 12, n)
      `CHK("frozen pulse", 6, rl)
      // reset values and masked read back on the last chip select
      for (i = 0; i < 4; i++) begin
         wbx(1'h0, 8'h70 + 8'(4 * i), 32'h0);
         `CHK("reset word", 32'h0, q)
         wbx(1'h1, 8'h70 + 8'(4 * i), 32'hFFFFFFFF);
         wbx(1'h0, 8'h70 + 8'(4 * i), 32'h0);
         `CHK("read mask", mask[i], q)
      end
      wbx(1'h0, 8'h14, 32'h0);
      `CHK("cs stride", 32'h03030303, q)
      wbx(1'h1, 8'h80, 32'hFFFFFFFF);
      wbx(1'h0, 8'h80, 32'h0);
      `CHK("unmapped", 32'h0, q)
      wbx(1'h0, 8'h00, 32'h0);
      `CHK("unmapped dropped", 32'h0, q)
      // wait codes off, reserved, frozen, ready with a two-cycle wait
      wait_len <= 4'h2;
      for (i = 0; i < 4; i++) begin
         cfg(3'h0, 32'h01010101, 32'h03030303, 32'h00060006, 32'h2003 | (32'(i) << 4), 1'h1);
         acc(1'h0, 3'h0, 26'h0, 4'hF);
         `CHK("wait cycles", wn[i], n)
         `CHK("read pulse", wr[i], rl)
      end
      wait_len <= 4'h0;
      // high bits of setup, pulse and total fields
      cfg(3'h2, 32'h20200000, 32'h41410000, 32'h01FF0000, 32'h00002003, 1'h1);
      acc(1'h0, 3'h2, 26'h0, 4'hF);
      `CHK("long cycles", 898, n)
      `CHK("long pulse", 257, rl)
      // lane schemes: byte select, byte write, 8-bit bus
      for (i = 0; i < 3; i++) begin
         cfg(3'h3, 32'h01010101, 32'h03030303, 32'h00060006, wmd[i], 1'h1);
         acc(1'h1, 3'h3, 26'h0, 4'h5);
         `CHK("write cycles", 9, n)
         `CHK("lane strobes", elw[i], lw)
         `CHK("byte selects", ebs[i], bs)
         `CHK("write strobe", (i == 1) ? 1'h0 : 1'h1, wl)
      end
      // page reads: first access, hit, new page
      cfg(3'h4, 32'h01010101, 32'h05020000, 32'h00060006, 32'h01102001, 1'h1);
      for (i = 0; i < 3; i++) begin
         acc(1'h0, 3'h4, pa[i], 4'hF);
         `CHK("page cycles", pn[i], n)
         `CHK("page hit", (i == 1) ? 1'h1 : 1'h0, page_hit_o)
      end
      conclude();
   end
endmodule // tb_top
